// *** hw/kwu_consts.svh ***
`ifndef KWU_CONSTS_SVH
`define KWU_CONSTS_SVH

// register indices; byte address is four times the index
`define KWU_WAKE_EN_IDX  10'h031
`define KWU_SYSCTL_IDX   10'h032
`define KWU_STATUS_IDX   10'h033

// field positions
`define KWU_EN_MSB       7
`define KWU_EN_LSB       4
`define KWU_RELM_BIT     0
`define KWU_HALT_BIT     1

// reset values
`define KWU_WAKE_EN_RST  4'h0
`define KWU_RELM_RST     1'b1

// warm-up time and clock period, both in ns
`define KWU_WARMUP_NS    51200
`define KWU_CLK_NS       50
`define KWU_WARMUP_CYCLES ((`KWU_WARMUP_NS + `KWU_CLK_NS - 1) / `KWU_CLK_NS)

`endif

// *** hw/kwu_pkg.sv ***
package kwu_pkg;

  typedef enum logic [1:0]
  {
    ST_RUN    = 2'b00,
    ST_HALT   = 2'b01,
    ST_WARMUP = 2'b10
  } seq_state_t;

  typedef struct packed
  {
    seq_state_t  state;
    logic [3:0]  wake_en;
    logic        relm;
    logic        armed;
    logic [10:0] cnt;
    logic [31:0] prdata;
    logic        pslverr;
  } ctrl_t;

  typedef struct packed
  {
    logic [4:0] meta;
    logic [4:0] sync;
  } sync_t;

  // release condition; level mode ors the pins, edge mode needs a prior low
  function automatic logic release_cond(input logic       relm,
                                        input logic       armed,
                                        input logic       rel,
                                        input logic [3:0] en,
                                        input logic [3:0] wake);
    if (relm)
      return rel | (|(en & ~wake));
    else
      return armed & rel;
  endfunction

endpackage

// *** hw/wake_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module wake_sync
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       rel_pin_in,
  input  wire logic [3:0] wake_pin_in,
  input  wire logic [3:0] wake_en_in,
  input  wire logic       relm_in,
  input  wire logic       armed_in,
  output logic            rel_sync_out,
  output logic [3:0]      wake_sync_out,
  output logic            req_async_out
);

  kwu_pkg::sync_t q;
  kwu_pkg::sync_t next_q;

  // two-stage synchroniser; meta feeds only the second stage
  always_comb
  begin
    next_q      = q;
    next_q.meta = {rel_pin_in, wake_pin_in};
    next_q.sync = q.meta;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      q <= '{meta: 5'h0f, sync: 5'h0f};
    else
      q <= next_q;
  end

  assign rel_sync_out  = q.sync[4];
  assign wake_sync_out = q.sync[3:0];

  // clockless path: raw pins straight to the oscillator start request [RQ15]
  assign req_async_out = kwu_pkg::release_cond(relm_in, armed_in, rel_pin_in,
                                               wake_en_in, wake_pin_in);

endmodule

`default_nettype wire

// *** hw/key_wakeup.sv ***
// Overview of operation
// RQ1: four wake pins plus release pin end halt
// RQ2: one enable bit per wake pin
// RQ3: enables in bits 7..4, write only
// RQ4: enables cleared after reset
// RQ5: software sets wake pins to input first
// RQ6: enabled wake pin low ends halt
// RQ7: wake pin levels readable by software
// RQ8: software checks enabled pins high first
// RQ9: release active at halt: go to warm-up
// RQ10: edge mode: wake pins disabled or high
// RQ11: release pin level or edge; wake level only
// RQ12: release pin always acts as release input
// RQ13: release pin held low for wake release
// RQ14: enabled wake pin not analog input
// RQ15: clockless OR of conditions starts warm-up
`timescale 1ns/1ps
`default_nettype none
`include "kwu_consts.svh"

module key_wakeup
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        RELEASE_PIN_IN,
  input  wire logic        KEY_WAKE_IN2_IN,
  input  wire logic        KEY_WAKE_IN3_IN,
  input  wire logic        KEY_WAKE_IN4_IN,
  input  wire logic        KEY_WAKE_IN5_IN,
  output logic             HALT_OUT,
  output logic             WARMUP_OUT,
  output logic             OSC_ENABLE_OUT,
  output logic             RELEASE_REQ_OUT
);

  localparam logic [10:0] WARMUP_LAST = 11'(`KWU_WARMUP_CYCLES - 1);

  kwu_pkg::ctrl_t q;
  kwu_pkg::ctrl_t next_q;

  logic       rel_s;
  logic [3:0] wake_s;
  logic       req_async;
  logic       setup;
  logic       access_wr;
  logic       halt_req;
  logic       instant_rel;
  logic       sync_rel;

  // wake pin 2 sits at bit 0, pin 5 at bit 3 [RQ1]
  wake_sync u_sync
  (
    .clk_in        (CLOCK_IN),
    .resetn_in     (RESETN_IN),
    .rel_pin_in    (RELEASE_PIN_IN),
    .wake_pin_in   ({KEY_WAKE_IN5_IN, KEY_WAKE_IN4_IN, KEY_WAKE_IN3_IN, KEY_WAKE_IN2_IN}),
    .wake_en_in    (q.wake_en),
    .relm_in       (q.relm),
    .armed_in      (q.armed),
    .rel_sync_out  (rel_s),
    .wake_sync_out (wake_s),
    .req_async_out (req_async)
  );

  // apb phases; zero wait states, so pready is always high
  assign setup     = PSEL_IN & ~PENABLE_IN;
  assign access_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign halt_req  = access_wr && (PADDR_IN[11:2] == `KWU_SYSCTL_IDX)
                     && PWDATA_IN[`KWU_HALT_BIT] && (q.state == kwu_pkg::ST_RUN);

  // halt attempt while a release is already pending never halts [RQ9]
  assign instant_rel = rel_s | (|(q.wake_en & ~wake_s));
  assign sync_rel    = kwu_pkg::release_cond(q.relm, q.armed, rel_s, q.wake_en, wake_s);

  always_comb
  begin
    next_q = q;
    // read data and error captured in setup so they stand in the access phase
    if (setup)
    begin
      next_q.prdata  = 32'h0;
      next_q.pslverr = 1'b0;
      if (PADDR_IN[11:2] == `KWU_WAKE_EN_IDX)
        next_q.prdata = 32'h0; // write-only, reads zero [RQ3]
      else if (PADDR_IN[11:2] == `KWU_SYSCTL_IDX)
        next_q.prdata = {30'h0, (q.state == kwu_pkg::ST_HALT), q.relm};
      else if (PADDR_IN[11:2] == `KWU_STATUS_IDX)
        next_q.prdata = {25'h0, (q.state == kwu_pkg::ST_WARMUP),
                         (q.state == kwu_pkg::ST_HALT), rel_s, wake_s}; // [RQ7]
      else
        next_q.pslverr = 1'b1;
    end
    // register writes take effect at the access edge
    if (access_wr)
    begin
      if (PADDR_IN[11:2] == `KWU_WAKE_EN_IDX)
        next_q.wake_en = PWDATA_IN[`KWU_EN_MSB:`KWU_EN_LSB]; // [RQ2] [RQ3]
      else if (PADDR_IN[11:2] == `KWU_SYSCTL_IDX)
        next_q.relm = PWDATA_IN[`KWU_RELM_BIT];
    end
    // halt / warm-up sequencer
    case (q.state)
      kwu_pkg::ST_RUN:
      begin
        next_q.armed = 1'b0;
        next_q.cnt   = 11'h000;
        if (halt_req)
        begin
          if (instant_rel)
            next_q.state = kwu_pkg::ST_WARMUP; // [RQ9]
          else
            next_q.state = kwu_pkg::ST_HALT;
        end
      end
      kwu_pkg::ST_HALT:
      begin
        // edge mode needs the release pin seen low before a rise counts [RQ11]
        if (!rel_s)
          next_q.armed = 1'b1;
        if (sync_rel)
          next_q.state = kwu_pkg::ST_WARMUP; // [RQ6] [RQ11]
      end
      kwu_pkg::ST_WARMUP:
      begin
        next_q.armed = 1'b0;
        next_q.cnt   = q.cnt + 11'h001;
        if (q.cnt == WARMUP_LAST)
          next_q.state = kwu_pkg::ST_RUN;
      end
      default:
        next_q.state = kwu_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      q         <= '0;
      q.state   <= kwu_pkg::ST_RUN;
      q.wake_en <= `KWU_WAKE_EN_RST; // [RQ4]
      q.relm    <= `KWU_RELM_RST;
    end
    else
      q <= next_q;
  end

  assign PRDATA_OUT  = q.prdata;
  assign PSLVERR_OUT = q.pslverr;
  assign PREADY_OUT  = 1'b1;
  assign HALT_OUT    = (q.state == kwu_pkg::ST_HALT);
  assign WARMUP_OUT  = (q.state == kwu_pkg::ST_WARMUP);

  // oscillator restarts straight from the pins, not waiting for the synchroniser
  assign RELEASE_REQ_OUT = req_async & (q.state == kwu_pkg::ST_HALT); // [RQ15]
  assign OSC_ENABLE_OUT  = (q.state != kwu_pkg::ST_HALT) | req_async; // [RQ15]

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  AST_WAKE_EN_WRITE: assert property ( // [RQ2] [RQ3]
    access_wr && PADDR_IN[11:2] == `KWU_WAKE_EN_IDX
    |=> q.wake_en == $past(PWDATA_IN[7:4]))
    else $error("wake enable not taken from bits 7..4");

  AST_WAKE_EN_RESET: assert property ( // [RQ4]
    disable iff (1'b0) !RESETN_IN |=> q.wake_en == 4'h0)
    else $error("wake enables not cleared by reset");

  AST_WO_READS_ZERO: assert property ( // [RQ3]
    setup && PADDR_IN[11:2] == `KWU_WAKE_EN_IDX ##1 PENABLE_IN |-> PRDATA_OUT == 32'h0)
    else $error("write-only register returned data");

  AST_LEVEL_WAKE: assert property ( // [RQ1] [RQ6]
    q.state == kwu_pkg::ST_HALT && q.relm && (|(q.wake_en & ~wake_s))
    |=> q.state == kwu_pkg::ST_WARMUP)
    else $error("enabled low wake pin did not end halt");

  AST_PIN_READ: assert property ( // [RQ7]
    setup && PADDR_IN[11:2] == `KWU_STATUS_IDX |=> PRDATA_OUT[3:0] == $past(wake_s))
    else $error("status read does not show wake pin levels");

  AST_NO_HALT: assert property ( // [RQ9]
    halt_req && instant_rel |=> q.state == kwu_pkg::ST_WARMUP ##1 q.state != kwu_pkg::ST_HALT)
    else $error("halted despite pending release");

  AST_EDGE_MODE: assert property ( // [RQ11]
    q.state == kwu_pkg::ST_HALT && !q.relm && !rel_s |=> q.state == kwu_pkg::ST_HALT)
    else $error("edge mode released without a rising release pin");

  AST_ASYNC_REQ: assert property ( // [RQ15]
    q.state == kwu_pkg::ST_HALT && q.relm && RELEASE_PIN_IN |-> RELEASE_REQ_OUT && OSC_ENABLE_OUT)
    else $error("clockless release request missing");

  AST_WARMUP_LEN: assert property ( // [RQ9]
    $rose(WARMUP_OUT) |-> WARMUP_OUT [*8])
    else $error("warm-up ended too early");

  // the counter, not the pins, decides when warm-up is over
  AST_WARMUP_COUNT: assert property ( // [RQ9]
    q.state == kwu_pkg::ST_WARMUP && q.cnt != WARMUP_LAST |=> q.state == kwu_pkg::ST_WARMUP)
    else $error("warm-up left before its count ran out");

  // oscillator must stay off while halted with no raw release condition
  AST_OSC_OFF_HALT: assert property ( // [RQ15]
    q.state == kwu_pkg::ST_HALT && !req_async |-> !OSC_ENABLE_OUT && !RELEASE_REQ_OUT)
    else $error("oscillator running in halt without release");

  // a clean halt write with no pending release really halts
  AST_HALT_ENTRY: assert property ( // [RQ6]
    halt_req && !instant_rel |=> HALT_OUT)
    else $error("halt write did not halt");

endmodule

`default_nettype wire

// *** bench/key_source.sv ***
`timescale 1ns/1ps
`default_nettype none

module key_source
(
  input  wire logic       rel_level_in,
  input  wire logic [3:0] press_in,
  output logic            rel_pin_out,
  output logic [3:0]      wake_pin_out
);
  // keys pull low while pressed; release pin forced low under a key
  // keys are plain digital levels, never analog inputs
  always_comb
  begin
    wake_pin_out = ~press_in;
    rel_pin_out  = rel_level_in & ~(|press_in);
  end
endmodule

`default_nettype wire

// *** bench/test_key_wakeup.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "kwu_consts.svh"

module test_key_wakeup;
  localparam logic [11:0] EN_A = {`KWU_WAKE_EN_IDX, 2'b00};
  localparam logic [11:0] SC_A = {`KWU_SYSCTL_IDX, 2'b00};
  localparam logic [11:0] ST_A = {`KWU_STATUS_IDX, 2'b00};
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        rel_level = 1'b0, pready, pslverr, err, halt, warm, osc_en, req, rel_pin;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  press = 4'h0, wake;
  int          mismatches = 0, n_checks = 0, k, o;

  always #25 clk = ~clk;

  key_source keys (.rel_level_in(rel_level), .press_in(press), .rel_pin_out(rel_pin),
                   .wake_pin_out(wake));
  key_wakeup dut (.CLOCK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RELEASE_PIN_IN(rel_pin),
    .KEY_WAKE_IN2_IN(wake[0]), .KEY_WAKE_IN3_IN(wake[1]), .KEY_WAKE_IN4_IN(wake[2]),
    .KEY_WAKE_IN5_IN(wake[3]), .HALT_OUT(halt), .WARMUP_OUT(warm),
    .OSC_ENABLE_OUT(osc_en), .RELEASE_REQ_OUT(req));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer; request held until pready is seen at an access edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1)
      mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask

  // waits a few cycles for warm-up; pins pass a two-flop synchroniser first
  task automatic expect_warm(input logic exp);
    for (int t = 0; t < 8 && warm !== 1'b1; t++)
    begin
      @(posedge clk);
      #1;
    end
    check("warmup", {31'h0, exp}, {31'h0, warm});
  endtask

  task automatic run_warm;
    int n;
    n = 0;
    while (warm === 1'b1 && n < 1100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("warmup length", 32'h1, {31'h0, n >= 1018 && n <= 1025});
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #(50 * 30000);
    mismatches++;
    wrap_up;
  end

  initial
  begin
    void'($urandom(32'ha10d));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, ST_A, 32'h0);
    check("status", 32'h0f, rd & 32'h7f);
    apb(1'b0, EN_A, 32'h0);
    check("enable read", 32'h0, rd);
    apb(1'b0, 12'h0fc, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    // enables clear after reset: no key may wake
    apb(1'b1, SC_A, 32'h3);
    check("halted", 32'h1, {31'h0, halt});
    check("osc off", 32'h0, {31'h0, osc_en});
    @(posedge clk);
    press <= 4'hf;
    expect_warm(1'b0);
    @(posedge clk);
    press <= 4'h0;
    rel_level <= 1'b1;
    expect_warm(1'b1);
    rel_level <= 1'b0;
    run_warm;
    for (k = 0; k < 4; k++)
    begin
      o = (k + 1 + $urandom_range(2)) % 4;
      apb(1'b1, EN_A, 32'h10 << k);
      apb(1'b0, ST_A, 32'h0);
      check("pins idle", 32'hf, rd & 32'hf);
      apb(1'b1, SC_A, 32'h3);
      @(posedge clk);
      press <= 4'h1 << o;
      expect_warm(1'b0);
      apb(1'b0, ST_A, 32'h0);
      check("pin level", 32'hf & ~(32'h1 << o), rd & 32'hf);
      @(posedge clk);
      press <= press | (4'h1 << k);
      #1;
      check("raw request", 32'h1, {31'h0, req});
      expect_warm(1'b1);
      press <= 4'h0;
      run_warm;
    end
    // pin already low when halting: straight to warm-up
    apb(1'b1, EN_A, 32'h80);
    @(posedge clk);
    press <= 4'h8;
    apb(1'b1, SC_A, 32'h3);
    check("no halt", 32'h0, {31'h0, halt});
    expect_warm(1'b1);
    press <= 4'h0;
    run_warm;
    // edge mode: release pin rising edge ends the halt
    apb(1'b1, EN_A, 32'h0);
    apb(1'b1, SC_A, 32'h0);
    apb(1'b1, SC_A, 32'h2);
    check("edge halted", 32'h1, {31'h0, halt});
    repeat (4) @(posedge clk);
    rel_level <= 1'b1;
    expect_warm(1'b1);
    rel_level <= 1'b0;
    run_warm;
    wrap_up;
  end
endmodule

`default_nettype wire
